// ---- include/ied_pkg.sv ----
`default_nettype none

package ied_pkg;

  // opcodes and the masks that clear their register or pointer select
  localparam logic [7:0] OPC_INC_ACC    = 8'h04;
  localparam logic [7:0] OPC_INC_DIRECT = 8'h05;
  localparam logic [7:0] OPC_INC_IND    = 8'h06;
  localparam logic [7:0] OPC_INC_REG    = 8'h08;
  localparam logic [7:0] OPC_INC_DP     = 8'hA3;
  localparam logic [7:0] OPC_LOOP_REG   = 8'hD8;
  localparam logic [7:0] OPC_LOOP_DIR   = 8'hD5;
  localparam logic [7:0] MASK_REG_SEL   = 8'hF8;
  localparam logic [7:0] MASK_PTR_SEL   = 8'hFE;

  // operand spaces seen by the core's data path
  localparam logic [1:0] SPACE_ACC      = 2'h0;
  localparam logic [1:0] SPACE_DIRECT   = 2'h1;
  localparam logic [1:0] SPACE_INDIRECT = 2'h2;

  // instruction lengths in bytes and durations in machine cycles
  localparam logic [1:0] LEN_ONE        = 2'h1;
  localparam logic [1:0] LEN_TWO        = 2'h2;
  localparam logic [1:0] CYC_ONE        = 2'h1;
  localparam logic [1:0] CYC_TWO        = 2'h2;

  localparam int         MC_CLKS_DEF    = 12;
  localparam logic [15:0] DP_RESET      = 16'h0000;
  localparam logic [15:0] PC_RESET      = 16'h0000;

  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic       port_latch;
    logic [1:0] space;
    logic [7:0] addr;
    logic [7:0] wr_data;
  } ied_op_req_t;

  typedef struct packed {
    logic        done;
    logic        taken;
    logic        illegal;
    logic [15:0] next_pc;
  } ied_retire_t;

  typedef struct packed {
    logic       legal;
    logic       loop_br;
    logic       dp_inc;
    logic       ind;
    logic       reg_form;
    logic [1:0] space;
    logic [1:0] len;
    logic [1:0] cycles;
  } ied_dec_t;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_PTR_RD  = 6'b000010,
    ST_PTR_CAP = 6'b000100,
    ST_OP_RD   = 6'b001000,
    ST_OP_CAP  = 6'b010000,
    ST_WAIT    = 6'b100000
  } ied_state_t;

endpackage : ied_pkg

`default_nettype wire

// ---- core/ied_byte_step.sv ----
`default_nettype none

module ied_byte_step #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] value,
  input  wire logic             enable,
  input  wire logic             down,
  output logic      [WIDTH-1:0] result,
  output logic                  zero,
  output logic                  wrap
);

  localparam logic [WIDTH-1:0] ONE  = WIDTH'(1);
  localparam logic [WIDTH-1:0] ALL1 = '1;

  // plain modulo step; wrap marks all-ones to zero going up, zero to all-ones going down
  always_comb begin
    if (!enable) begin
      result = value;
      wrap   = 1'b0;
    end else if (down) begin
      result = value - ONE;
      wrap   = (value == '0);
    end else begin
      result = value + ONE;
      wrap   = (value == ALL1);
    end
    zero = (result == '0);
  end

endmodule : ied_byte_step

`default_nettype wire

// ---- core/ied_execute_unit.sv ----
`default_nettype none

// Function
// - read-modify-write operands come from the port output latch, never the pins.
// - register loop-branch is 11011rrr plus offset, two bytes, two machine cycles.
// - direct loop-branch advances pc by 2, decrements the byte, branches if nonzero.
// - a zero result skips the branch but the decremented value is written back.
// - a self loop spans from 2 up to 512 machine cycles.
// - byte increment wraps FF to 00, no flags; accumulator form 00000100, one cycle.
// - register form 00001rrr and indirect form 0000011i, one byte, one cycle each.
// - direct increment is 00000101 plus address, two bytes, one machine cycle.
// - data pointer increment is 10100011, 16-bit modulo, one byte, two cycles.
// - low byte rollover carries into the high byte; no flag changes.
// - the data pointer is the only 16-bit pair with an increment.
// - register loop-branch: pc plus two, decrement register, branch when nonzero.
// - branch target is next instruction address plus signed offset byte.
// - loop-branch works on working register or direct byte, wraps 00 to FF, no flags.
module ied_execute_unit #(
  parameter int MC_CLKS = ied_pkg::MC_CLKS_DEF
) (
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  input  wire logic                INSTR_VALID,
  input  wire logic [15:0]         INSTR_PC,
  input  wire logic [7:0]          INSTR_OPCODE,
  input  wire logic [7:0]          INSTR_OPERAND1,
  input  wire logic [7:0]          INSTR_OPERAND2,
  input  wire logic [1:0]          BANK_SEL,
  input  wire logic [7:0]          OP_RD_DATA,
  input  wire logic                DATA_POINTER_LOAD,
  input  wire logic [15:0]         DATA_POINTER_NEW,
  output logic                     INSTR_READY,
  output ied_pkg::ied_op_req_t     OP_REQ,
  output ied_pkg::ied_retire_t     RETIRE,
  output logic [15:0]              DATA_POINTER
);
  import ied_pkg::*;

  localparam logic [7:0] MC_LAST = 8'(MC_CLKS - 1);
  localparam logic [7:0] MC_PRE  = 8'(MC_CLKS - 2);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [1:0] LEFT_ONE = 2'h1;

  function automatic ied_dec_t decode(input logic [7:0] opc);
    ied_dec_t d;
    d = '0;
    d.len    = LEN_ONE;
    d.cycles = CYC_ONE;
    d.space  = SPACE_DIRECT;
    if (opc == OPC_INC_ACC) begin
      d.legal = 1'b1;
      d.space = SPACE_ACC;
    end else if ((opc & MASK_REG_SEL) == OPC_INC_REG) begin
      d.legal    = 1'b1;
      d.reg_form = 1'b1;
    end else if ((opc & MASK_PTR_SEL) == OPC_INC_IND) begin
      d.legal = 1'b1;
      d.ind   = 1'b1;
    end else if (opc == OPC_INC_DIRECT) begin
      d.legal = 1'b1;
      d.len   = LEN_TWO;
    end else if (opc == OPC_INC_DP) begin
      d.legal  = 1'b1;
      d.dp_inc = 1'b1;
      d.cycles = CYC_TWO;
    end else if ((opc & MASK_REG_SEL) == OPC_LOOP_REG) begin
      d.legal    = 1'b1;
      d.loop_br  = 1'b1;
      d.reg_form = 1'b1;
      d.len      = LEN_TWO;
      d.cycles   = CYC_TWO;
    end else if (opc == OPC_LOOP_DIR) begin
      d.legal   = 1'b1;
      d.loop_br = 1'b1;
      d.len    = LEN_TWO;
      d.cycles = CYC_TWO;
    end
    return d;
  endfunction : decode

  ied_state_t  state_reg,   state_next;
  ied_dec_t    dec_reg,     dec_next;
  ied_op_req_t req_reg,     req_next;
  ied_retire_t ret_reg,     ret_next;
  logic [15:0] pc_reg,      pc_next;
  logic [7:0]  rel_reg,     rel_next;
  logic [7:0]  cnt_reg,     cnt_next;
  logic [1:0]  left_reg,    left_next;
  logic        nz_reg,      nz_next;
  logic        ready_reg,   ready_next;
  logic [15:0] dp_reg,      dp_next;

  ied_dec_t    dec_in;
  logic        tick;
  logic        pre_tick;
  logic [7:0]  step_result;
  logic        step_zero;
  logic [7:0]  dp_lo_result;
  logic        dp_lo_wrap;
  logic [7:0]  dp_hi_result;
  logic [15:0] seq_pc;
  logic [15:0] target_pc;

  // one shared byte stepper: down for the loop-branch, up for the byte increments; the data pointer has its own two
  ied_byte_step #(.WIDTH(8)) u_operand_step (
    .value  (OP_RD_DATA),
    .enable (1'b1),
    .down   (dec_reg.loop_br),
    .result (step_result),
    .zero   (step_zero),
    .wrap   ()
  );

  ied_byte_step #(.WIDTH(8)) u_dp_lo_step (
    .value  (dp_reg[7:0]),
    .enable (1'b1),
    .down   (1'b0),
    .result (dp_lo_result),
    .zero   (),
    .wrap   (dp_lo_wrap)
  );

  // high byte only moves when the low byte rolls over
  ied_byte_step #(.WIDTH(8)) u_dp_hi_step (
    .value  (dp_reg[15:8]),
    .enable (dp_lo_wrap),
    .down   (1'b0),
    .result (dp_hi_result),
    .zero   (),
    .wrap   ()
  );

  always_comb begin
    dec_in    = decode(INSTR_OPCODE);
    tick      = (cnt_reg == MC_LAST);
    pre_tick  = (cnt_reg == MC_PRE);
    seq_pc    = pc_reg + {14'h0000, dec_reg.len};
    target_pc = seq_pc + {{8{rel_reg[7]}}, rel_reg};
  end

  always_comb begin
    state_next     = state_reg;
    dec_next       = dec_reg;
    req_next       = req_reg;
    req_next.rd_en = 1'b0;
    req_next.wr_en = 1'b0;
    ret_next       = ret_reg;
    ret_next.done  = 1'b0;
    pc_next        = pc_reg;
    rel_next       = rel_reg;
    nz_next        = nz_reg;
    dp_next        = dp_reg;
    left_next      = left_reg;
    cnt_next       = tick ? 8'h00 : cnt_reg + CNT_ONE;
    if (tick && state_reg != ST_IDLE) begin
      left_next = left_reg - LEFT_ONE;
    end
    if (DATA_POINTER_LOAD) begin
      dp_next = DATA_POINTER_NEW;
    end
    case (state_reg)
      ST_IDLE: begin
        if (INSTR_VALID && ready_reg) begin
          dec_next  = dec_in;
          pc_next   = INSTR_PC;
          rel_next  = (INSTR_OPCODE == OPC_LOOP_DIR) ? INSTR_OPERAND2 : INSTR_OPERAND1;
          left_next = dec_in.cycles;
          nz_next   = 1'b0;
          req_next.space      = dec_in.space;
          req_next.port_latch = 1'b1;
          if (dec_in.reg_form) begin
            req_next.addr = {3'b000, BANK_SEL, INSTR_OPCODE[2:0]};
          end else begin
            req_next.addr = INSTR_OPERAND1;
          end
          if (dec_in.dp_inc || !dec_in.legal) begin
            state_next = ST_WAIT;
          end else if (dec_in.ind) begin
            // pointer fetch is a plain read of the working register
            req_next.space      = SPACE_DIRECT;
            req_next.port_latch = 1'b0;
            req_next.addr       = {3'b000, BANK_SEL, 2'b00, INSTR_OPCODE[0]};
            req_next.rd_en      = 1'b1;
            state_next          = ST_PTR_RD;
          end else begin
            req_next.rd_en = 1'b1;
            state_next     = ST_OP_RD;
          end
        end
      end
      ST_PTR_RD: begin
        state_next = ST_PTR_CAP;
      end
      ST_PTR_CAP: begin
        req_next.space      = SPACE_INDIRECT;
        req_next.addr       = OP_RD_DATA;
        req_next.port_latch = 1'b1;
        req_next.rd_en      = 1'b1;
        state_next          = ST_OP_RD;
      end
      ST_OP_RD: begin
        state_next = ST_OP_CAP;
      end
      ST_OP_CAP: begin
        // result is always written back, zero or not; no flag is touched
        req_next.wr_data = step_result;
        req_next.wr_en   = 1'b1;
        nz_next          = dec_reg.loop_br && !step_zero;
        state_next       = ST_WAIT;
      end
      ST_WAIT: begin
        // retire one clock before the machine-cycle boundary so the next
        // opcode can be taken on that boundary with no lost cycle
        if (pre_tick && left_reg == LEFT_ONE) begin
          ret_next.done    = 1'b1;
          ret_next.taken   = nz_reg;
          ret_next.illegal = !dec_reg.legal;
          ret_next.next_pc = nz_reg ? target_pc : seq_pc;
          if (dec_reg.dp_inc) begin
            dp_next = {dp_hi_result, dp_lo_result};
          end
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // opcodes are only taken on a machine-cycle boundary while idle
    ready_next = (state_next == ST_IDLE) && (cnt_next == MC_LAST);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      dec_reg   <= '0;
      req_reg   <= '0;
      ret_reg   <= '0;
      pc_reg    <= PC_RESET;
      rel_reg   <= 8'h00;
      cnt_reg   <= 8'h00;
      left_reg  <= 2'h0;
      nz_reg    <= 1'b0;
      ready_reg <= 1'b0;
      dp_reg    <= DP_RESET;
    end else begin
      state_reg <= state_next;
      dec_reg   <= dec_next;
      req_reg   <= req_next;
      ret_reg   <= ret_next;
      pc_reg    <= pc_next;
      rel_reg   <= rel_next;
      cnt_reg   <= cnt_next;
      left_reg  <= left_next;
      nz_reg    <= nz_next;
      ready_reg <= ready_next;
      dp_reg    <= dp_next;
    end
  end

  always_comb begin
    INSTR_READY  = ready_reg;
    OP_REQ       = req_reg;
    RETIRE       = ret_reg;
    DATA_POINTER = dp_reg;
  end

endmodule : ied_execute_unit

`default_nettype wire

// ---- tb/ied_unit_properties.sv ----
`default_nettype none

module ied_unit_properties
  import ied_pkg::*;
#(
  parameter int MC_CLKS = 12
) (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        INSTR_VALID,
  input wire logic        INSTR_READY,
  input wire logic [15:0] INSTR_PC,
  input wire logic [7:0]  INSTR_OPCODE,
  input wire logic [7:0]  INSTR_OPERAND1,
  input wire logic        DATA_POINTER_LOAD,
  input wire ied_op_req_t OP_REQ,
  input wire ied_retire_t RETIRE,
  input wire logic [15:0] DATA_POINTER
);
  // retire is launched on edge N*MC_CLKS-1 after the take, so it is sampled one edge later
  localparam int D1 = MC_CLKS;
  localparam int D2 = 2 * MC_CLKS;
  logic       take;
  logic [7:0] opc;
  logic       loop_reg;
  assign take     = INSTR_READY && INSTR_VALID;
  assign opc      = INSTR_OPCODE;
  assign loop_reg = (opc & MASK_REG_SEL) == OPC_LOOP_REG;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  inc_acc_a: assert property (take && opc == OPC_INC_ACC |-> ##D1 RETIRE.done
    && RETIRE.next_pc == $past(INSTR_PC, D1) + 16'h1) else $error("inc acc retire wrong");
  inc_dir_a: assert property (take && opc == OPC_INC_DIRECT |-> ##D1 RETIRE.done
    && RETIRE.next_pc == $past(INSTR_PC, D1) + 16'h2) else $error("inc direct retire wrong");
  inc_reg_a: assert property (take && ((opc & MASK_REG_SEL) == OPC_INC_REG
    || (opc & MASK_PTR_SEL) == OPC_INC_IND) |-> ##D1 RETIRE.done && !RETIRE.illegal)
    else $error("inc register retire wrong");
  loop_cycles_a: assert property (take && loop_reg |-> ##D1 !RETIRE.done
    ##MC_CLKS RETIRE.done) else $error("loop branch length wrong");
  loop_target_a: assert property (take && loop_reg |-> ##D2
    RETIRE.taken == (OP_REQ.wr_data != 8'h00) && RETIRE.next_pc == $past(INSTR_PC, D2)
    + 16'h2 + (RETIRE.taken ? {{8{$past(INSTR_OPERAND1[7], D2)}},
    $past(INSTR_OPERAND1, D2)} : 16'h0)) else $error("loop branch target wrong");
  dp_inc_a: assert property (take && opc == OPC_INC_DP && !DATA_POINTER_LOAD |-> ##D2
    RETIRE.done && DATA_POINTER == $past(DATA_POINTER, D2) + 16'h1)
    else $error("pointer increment wrong");
  rmw_latch_a: assert property (OP_REQ.wr_en |-> OP_REQ.port_latch)
    else $error("write back not from latch read");
  ready_gap_a: assert property (INSTR_READY |=> !INSTR_READY [*5])
    else $error("ready pulses too close");
  done_ready_a: assert property (RETIRE.done |-> INSTR_READY)
    else $error("no ready with retire");

  cover property (take && opc == OPC_INC_DP);
  cover property (RETIRE.done && !RETIRE.taken && !RETIRE.illegal);
  cover property (RETIRE.done && RETIRE.taken);
  cover property (RETIRE.done && RETIRE.illegal);
endmodule : ied_unit_properties

bind ied_execute_unit ied_unit_properties #(.MC_CLKS(MC_CLKS)) i_ied_unit_properties (
  .CLK(CLK), .SYS_RST(SYS_RST), .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY),
  .INSTR_PC(INSTR_PC), .INSTR_OPCODE(INSTR_OPCODE), .INSTR_OPERAND1(INSTR_OPERAND1),
  .DATA_POINTER_LOAD(DATA_POINTER_LOAD), .OP_REQ(OP_REQ), .RETIRE(RETIRE),
  .DATA_POINTER(DATA_POINTER)
);

`default_nettype wire

// ---- tb/test_inc_decrement_branch_nonzero_execute_unit.sv ----
`default_nettype none

module test_inc_decrement_branch_nonzero_execute_unit
  import ied_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 7;
  logic        clk;
  logic        rst;
  logic        valid;
  logic        dp_load;
  logic        ready;
  logic [15:0] pc;
  logic [15:0] dp_data;
  logic [15:0] dp_seen;
  logic [7:0]  opc;
  logic [7:0]  op1;
  logic [7:0]  op2;
  logic [7:0]  rd_data;
  logic [7:0]  acc;
  logic [1:0]  bank;
  ied_op_req_t req;
  ied_retire_t ret;
  logic [7:0]  mem [256];
  int          bad_count;
  int          samples_checked;
  int          cycles;

  ied_execute_unit #(.MC_CLKS(MC)) i_ied_execute_unit (
    .CLK(clk), .SYS_RST(rst), .INSTR_VALID(valid), .INSTR_PC(pc), .INSTR_OPCODE(opc),
    .INSTR_OPERAND1(op1), .INSTR_OPERAND2(op2), .BANK_SEL(bank), .OP_RD_DATA(rd_data),
    .DATA_POINTER_LOAD(dp_load), .DATA_POINTER_NEW(dp_data), .INSTR_READY(ready),
    .OP_REQ(req), .RETIRE(ret), .DATA_POINTER(dp_seen)
  );

  always #4 clk = ~clk;

  // the request is taken as it stands at the edge; read data follows in the next
  // clock and is good for that clock only, otherwise it is scrambled on purpose
  always @(posedge clk) begin : mem_model
    ied_op_req_t q;
    q = req;
    #1;
    rd_data <= q.rd_en ? (q.space == SPACE_ACC ? acc : mem[q.addr]) : ~rd_data;
    if (q.wr_en && q.space == SPACE_ACC)
      acc <= q.wr_data;
    else if (q.wr_en)
      mem[q.addr] <= q.wr_data;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // waits for the offer to be taken, then times the retire from the take edge
  task automatic run(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b,
                     input int n, input logic [15:0] npc, input logic tk, input logic ill);
    int k;
    valid = 1'b1;
    opc = o;
    op1 = a;
    op2 = b;
    do @(posedge clk); while (!ready);
    #1 valid = 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!ret.done && k < 40);
    check("cycles", 16'(k), 16'(n * MC));
    check("next pc", ret.next_pc, npc);
    check("taken", 16'(ret.taken), 16'(tk));
    check("illegal", 16'(ret.illegal), 16'(ill));
    #1;
  endtask : run

  task automatic t_inc_byte();
    acc = 8'hFF;
    run(OPC_INC_ACC, 8'h00, 8'h00, 1, 16'h0101, 1'b0, 1'b0);
    check("acc", 16'(acc), 16'h0000);
    bank = 2'h2;
    mem[8'h15] = 8'h7F;
    run(OPC_INC_REG | 8'h05, 8'h00, 8'h00, 1, 16'h0101, 1'b0, 1'b0);
    check("reg", 16'(mem[8'h15]), 16'h0080);
    mem[8'h11] = 8'h7E;
    mem[8'h7E] = 8'hFF;
    run(OPC_INC_IND | 8'h01, 8'h00, 8'h00, 1, 16'h0101, 1'b0, 1'b0);
    check("indirect", 16'(mem[8'h7E]), 16'h0000);
    check("pointer", 16'(mem[8'h11]), 16'h007E);
    mem[8'h90] = 8'h40;
    run(OPC_INC_DIRECT, 8'h90, 8'h00, 1, 16'h0102, 1'b0, 1'b0);
    check("direct", 16'(mem[8'h90]), 16'h0041);
  endtask : t_inc_byte

  task automatic t_dp_inc();
    dp_data = 16'h12FE;
    dp_load = 1'b1;
    @(posedge clk) #1 dp_load = 1'b0;
    repeat (3) run(OPC_INC_DP, 8'h00, 8'h00, 2, 16'h0101, 1'b0, 1'b0);
    check("pointer carry", dp_seen, 16'h1301);
    dp_data = 16'hFFFF;
    dp_load = 1'b1;
    @(posedge clk) #1 dp_load = 1'b0;
    run(OPC_INC_DP, 8'h00, 8'h00, 2, 16'h0101, 1'b0, 1'b0);
    check("pointer wrap", dp_seen, 16'h0000);
  endtask : t_dp_inc

  task automatic t_loop_dir();
    mem[8'h40] = 8'h01;
    mem[8'h50] = 8'h70;
    mem[8'h60] = 8'h00;
    run(OPC_LOOP_DIR, 8'h40, 8'hF0, 2, 16'h0102, 1'b0, 1'b0);
    check("zero", 16'(mem[8'h40]), 16'h0000);
    run(OPC_LOOP_DIR, 8'h50, 8'hF0, 2, 16'h00F2, 1'b1, 1'b0);
    check("dec", 16'(mem[8'h50]), 16'h006F);
    run(OPC_LOOP_DIR, 8'h60, 8'h05, 2, 16'h0107, 1'b1, 1'b0);
    check("underflow", 16'(mem[8'h60]), 16'h00FF);
  endtask : t_loop_dir

  task automatic t_loop_reg();
    bank = 2'h3;
    mem[8'h1A] = 8'h03;
    repeat (2) run(OPC_LOOP_REG | 8'h02, 8'hFE, 8'h00, 2, 16'h0100, 1'b1, 1'b0);
    run(OPC_LOOP_REG | 8'h02, 8'hFE, 8'h00, 2, 16'h0102, 1'b0, 1'b0);
    check("count", 16'(mem[8'h1A]), 16'h0000);
  endtask : t_loop_reg

  task automatic t_illegal();
    run(8'h15, 8'h90, 8'h00, 1, 16'h0101, 1'b0, 1'b1);
    run(8'hA5, 8'h90, 8'h00, 1, 16'h0101, 1'b0, 1'b1);
    check("untouched", 16'(mem[8'h90]), 16'h0041);
  endtask : t_illegal

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    valid = 1'b0;
    dp_load = 1'b0;
    pc = 16'h0100;
    dp_data = 16'h0000;
    opc = 8'h00;
    op1 = 8'h00;
    op2 = 8'h00;
    bank = 2'h0;
    rd_data = 8'h00;
    acc = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    check("pointer reset", dp_seen, DP_RESET);
    t_inc_byte();
    t_dp_inc();
    t_loop_dir();
    t_loop_reg();
    t_illegal();
    test_done();
  end
endmodule : test_inc_decrement_branch_nonzero_execute_unit

`default_nettype wire
